// [rtl/darb_bank.sv]
// Dual-access RAM bank: eight two-port blocks shared by CPU and DMA requesters.
// Assumes requesters hold a request until ready; one clock, async high reset.
// Storage lives in darb_ram_blk; the register window sits outside the bank.
`timescale 1ns/1ps
`include "darb_regs.svh"

module darb_bank (
   input  wire logic                clk,
   input  wire logic                sys_rst,
   input  wire darb_pkg::darb_req_t req   [`DARB_NREQ],
   output      logic                ready [`DARB_NREQ],
   output      darb_pkg::darb_rsp_t rsp   [`DARB_NREQ],
   output      darb_pkg::darb_win_t win_req,
   input  wire logic [15:0]         win_rdata
);

   function automatic darb_pkg::darb_dec_t decode(input int unsigned r,
                                                  input logic [31:0] a);
      darb_pkg::darb_dec_t d;
      logic [31:0]         loc;
      logic                dma;
      dma = (r >= `DARB_REQ_DMA0);
      if (dma) begin
         loc   = a - `DARB_DMA_OFFSET;
         d.hit = (a[31:16] == `DARB_DMA_HI);
      end else begin
         loc   = a;
         d.hit = (a[31:16] == `DARB_CPU_HI);
      end
      d.local_addr = loc[15:0];
      // Window sits inside block zero, so it is tested first
      if (loc[15:0] < `DARB_WIN_BYTES) begin
         d.tgt = `DARB_TGT_WIN;
      end else begin
         d.tgt = {1'b0, loc[15:13]};
      end
      return d;
   endfunction

   function automatic logic [1:0] capacity(input logic [3:0] t);
      return (t == `DARB_TGT_WIN) ? `DARB_CAP_WIN : `DARB_CAP_BLK;
   endfunction

   function automatic logic [31:0] lane_in(input logic        wide,
                                           input logic [31:0] w);
      return wide ? w : {w[15:0], w[15:0]};
   endfunction

   function automatic logic [31:0] lane_out(input logic        wide,
                                            input logic        half,
                                            input logic [31:0] rd);
      if (wide)
         return rd;
      return half ? {16'h0000, rd[31:16]} : {16'h0000, rd[15:0]};
   endfunction

   // Half-word write enables; a wide access ignores address bit 1
   function automatic logic [1:0] lane_wen(input logic wide,
                                           input logic half);
      if (wide)
         return 2'h3;
      return half ? 2'h2 : 2'h1;
   endfunction

   darb_pkg::darb_dec_t         dec      [`DARB_NREQ];
   logic [3:0]                  tgt      [`DARB_NREQ];
   logic                        half_sel [`DARB_NREQ];
   logic [`DARB_PAIR_W-1:0]     word_idx [`DARB_NREQ];
   logic                        want     [`DARB_NREQ];
   logic                        to_win   [`DARB_NREQ];
   logic                        take_rd  [`DARB_NREQ];
   logic                        grant    [`DARB_NREQ];
   logic                        port_of  [`DARB_NREQ];

   logic [3:0]                  sel      [`DARB_NTGT][2];
   logic                        sel_vld  [`DARB_NTGT][2];
   logic [31:0]                 blk_rd   [`DARB_NBLK][2];

   logic [31:0]                 rdata_d  [`DARB_NREQ];
   logic                        rvalid_q [`DARB_NREQ];
   logic [31:0]                 rdata_q  [`DARB_NREQ];

   genvar gr;
   generate
      for (gr = 0; gr < `DARB_NREQ; gr++) begin : g_req
         assign dec[gr]      = decode(gr, req[gr].addr);
         assign tgt[gr]      = dec[gr].tgt;
         assign half_sel[gr] = dec[gr].local_addr[1];
         assign word_idx[gr] = dec[gr].local_addr[12:2];
         assign want[gr]     = req[gr].valid && dec[gr].hit;
         assign to_win[gr]   = (dec[gr].tgt == `DARB_TGT_WIN);
         // Misses are swallowed so a stray address cannot hang its bus
         assign ready[gr]    = !want[gr] || grant[gr];
         assign take_rd[gr]  = req[gr].valid && ready[gr] && !req[gr].we;
         assign rsp[gr]      = '{rvalid: rvalid_q[gr],
                                 rdata:  rdata_q[gr]};
      end
   endgenerate

   // Fixed priority, lowest requester first; low ones can starve high ones
   always_comb begin
      logic [1:0] cnt [`DARB_NTGT];
      for (int t = 0; t < `DARB_NTGT; t++) begin
         cnt[t]        = 2'h0;
         sel[t][0]     = 4'h0;
         sel[t][1]     = 4'h0;
         sel_vld[t][0] = 1'b0;
         sel_vld[t][1] = 1'b0;
      end

      for (int r = 0; r < `DARB_NREQ; r++) begin
         grant[r]   = 1'b0;
         port_of[r] = 1'b0;
         if (want[r] && cnt[tgt[r]] < capacity(tgt[r])) begin
            grant[r]                        = 1'b1;
            port_of[r]                      = cnt[tgt[r]][0];
            sel[tgt[r]][cnt[tgt[r]][0]]     = 4'(r);
            sel_vld[tgt[r]][cnt[tgt[r]][0]] = 1'b1;
            cnt[tgt[r]]                     = cnt[tgt[r]] + 2'h1;
         end
      end
   end

   genvar gb;
   generate
      for (gb = 0; gb < `DARB_NBLK; gb++) begin : g_blk
         // Idle ports point at requester 0; their enables keep them harmless
         wire logic [3:0]              ra  = sel[gb][0];
         wire logic [3:0]              rb  = sel[gb][1];
         wire logic                    ea  = sel_vld[gb][0];
         wire logic                    eb  = sel_vld[gb][1];
         wire logic                    wea = req[ra].we;
         wire logic                    web = req[rb].we;
         wire logic [`DARB_PAIR_W-1:0] ia  = word_idx[ra];
         wire logic [`DARB_PAIR_W-1:0] ib  = word_idx[rb];

         wire logic [1:0]              wa  = lane_wen(req[ra].wide, half_sel[ra]);
         wire logic [1:0]              wb  = lane_wen(req[rb].wide, half_sel[rb]);
         wire logic [31:0]             da  = lane_in(req[ra].wide, req[ra].wdata);
         wire logic [31:0]             db  = lane_in(req[rb].wide, req[rb].wdata);
         // Two ports per block, so two accesses of any mix per cycle
         darb_ram_blk u_blk (
            .clk     (clk),
            .a_en    (ea),
            .a_we    (wea),
            .a_idx   (ia),
            .a_wen   (wa),
            .a_wdata (da),
            .a_rdata (blk_rd[gb][0]),
            .b_en    (eb),
            .b_we    (web),
            .b_idx   (ib),
            .b_wen   (wb),
            .b_wdata (db),
            .b_rdata (blk_rd[gb][1])
         );
      end
   endgenerate

   // Window is single ported and answers in the same cycle
   wire logic [3:0]  win_sel = sel[`DARB_TGT_WIN][0];
   wire logic        win_vld = sel_vld[`DARB_TGT_WIN][0];
   wire logic        win_we  = req[win_sel].we;
   wire logic [7:0]  win_off = dec[win_sel].local_addr[7:0];
   wire logic [15:0] win_wd  = req[win_sel].wdata[15:0];
   assign win_req = '{valid: win_vld, we: win_we, offset: win_off, wdata: win_wd};

   // Misses read as zero so software sees a defined value
   always_comb begin
      for (int r = 0; r < `DARB_NREQ; r++) begin
         if (!dec[r].hit) begin
            rdata_d[r] = 32'h0000_0000;
         end else if (to_win[r]) begin
            rdata_d[r] = {16'h0000, win_rdata};
         end else begin
            rdata_d[r] = lane_out(req[r].wide, half_sel[r],
                                  blk_rd[tgt[r][2:0]][port_of[r]]);
         end
      end
   end

   // Writes give no answer; only taken reads pulse rvalid
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int r = 0; r < `DARB_NREQ; r++) begin
            rvalid_q[r] <= 1'b0;
         end
      end else begin
         for (int r = 0; r < `DARB_NREQ; r++) begin
            rvalid_q[r] <= take_rd[r];
         end
      end
   end

   // Read data holds between reads, so a slow requester may sample late
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int r = 0; r < `DARB_NREQ; r++) begin
            rdata_q[r] <= 32'h0000_0000;
         end
      end else begin
         for (int r = 0; r < `DARB_NREQ; r++) begin
            if (take_rd[r])
               rdata_q[r] <= rdata_d[r];
         end
      end
   end

endmodule

// [rtl/darb_pkg.sv]
// Types shared by the dual-access RAM bank and its users.
// Assumes darb_regs.svh is on the include path.
`include "darb_regs.svh"

package darb_pkg;

   typedef struct packed {
      logic                    valid;
      logic                    we;
      logic                    wide;
      logic [`DARB_ADDR_W-1:0] addr;
      logic [`DARB_DATA_W-1:0] wdata;
   } darb_req_t;

   typedef struct packed {
      logic                    rvalid;
      logic [`DARB_DATA_W-1:0] rdata;
   } darb_rsp_t;

   typedef struct packed {
      logic                    valid;
      logic                    we;
      logic [7:0]              offset;
      logic [15:0]             wdata;
   } darb_win_t;

   typedef struct packed {
      logic        hit;
      logic [3:0]  tgt;
      logic [15:0] local_addr;
   } darb_dec_t;

endpackage

// [rtl/darb_ram_blk.sv]
// One 4K x 16 storage block with two independent access ports.
// Assumes the caller does arbitration; storage holds no reset value.
`timescale 1ns/1ps
`include "darb_regs.svh"

module darb_ram_blk (
   input  wire logic                    clk,
   input  wire logic                    a_en,
   input  wire logic                    a_we,
   input  wire logic [`DARB_PAIR_W-1:0] a_idx,
   input  wire logic [1:0]              a_wen,
   input  wire logic [31:0]             a_wdata,
   output      logic [31:0]             a_rdata,
   input  wire logic                    b_en,
   input  wire logic                    b_we,
   input  wire logic [`DARB_PAIR_W-1:0] b_idx,
   input  wire logic [1:0]              b_wen,
   input  wire logic [31:0]             b_wdata,
   output      logic [31:0]             b_rdata
);

   // Word pairs: low half is the even word
   logic [31:0] mem [0:`DARB_PAIRS-1];

   // Read-before-write: same-cycle read sees the old contents
   assign a_rdata = mem[a_idx];
   assign b_rdata = mem[b_idx];

   // Port b written last, so it wins a same-word collision
   always_ff @(posedge clk) begin
      if (a_en && a_we && a_wen[0]) mem[a_idx][15:0]  <= a_wdata[15:0];
      if (a_en && a_we && a_wen[1]) mem[a_idx][31:16] <= a_wdata[31:16];
      if (b_en && b_we && b_wen[0]) mem[b_idx][15:0]  <= b_wdata[15:0];
      if (b_en && b_we && b_wen[1]) mem[b_idx][31:16] <= b_wdata[31:16];
   end

endmodule

// [rtl/darb_regs.svh]
// Constants for the dual-access RAM bank: address map, sizes, requester layout.
// Included by the package and the design files; definitions only.
`ifndef DARB_REGS_SVH
`define DARB_REGS_SVH

`define DARB_ADDR_W      32
`define DARB_DATA_W      32
`define DARB_NREQ        10
`define DARB_NBLK        8
`define DARB_NTGT        9
`define DARB_TGT_WIN     4'h8
`define DARB_REQ_PROG    0
`define DARB_REQ_DMA0    6
`define DARB_CPU_HI      16'h0000
`define DARB_DMA_HI      16'h0001
`define DARB_DMA_OFFSET  32'h0001_0000
`define DARB_WIN_BYTES   16'h00C0
`define DARB_BLK_WORDS   4096
`define DARB_PAIRS       2048
`define DARB_PAIR_W      11
`define DARB_CAP_BLK     2'h2
`define DARB_CAP_WIN     2'h1

`endif

// [sim/darb_bank_properties.sv]
// Port checker for the dual-access RAM bank.
// Assumes a bind onto darb_bank; one clock, reset high.
`timescale 1ns/1ps
`include "darb_regs.svh"
module darb_bank_properties (
   input wire logic                clk,
   input wire logic                sys_rst,
   input wire darb_pkg::darb_req_t req [`DARB_NREQ],
   input wire logic                ready [`DARB_NREQ],
   input wire darb_pkg::darb_rsp_t rsp [`DARB_NREQ],
   input wire darb_pkg::darb_win_t win_req,
   input wire logic [15:0]         win_rdata
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   property p_rd; req[2].valid && ready[2] && !req[2].we |=> rsp[2].rvalid; endproperty
   a_rd: assert property (p_rd) else $error("read unanswered");
   property p_dma; rsp[6].rvalid |-> $past(req[6].valid && ready[6] && !req[6].we); endproperty
   a_dma: assert property (p_dma) else $error("stray answer");
   property p_two; !req[0].valid && !req[1].valid |-> ready[2]; endproperty
   a_two: assert property (p_two) else $error("lone request stalled");
   property p_stall; req[1].valid && req[2].valid && req[3].valid
      && req[1].addr[31:13] == req[3].addr[31:13] && req[2].addr[31:13] == req[3].addr[31:13]
      && req[3].addr[31:13] inside {[19'h1:19'h7]} |-> !ready[3]; endproperty
   a_stall: assert property (p_stall) else $error("third access granted");
   property p_nar; rsp[3].rvalid |-> rsp[3].rdata[31:16] == 16'h0000; endproperty
   a_nar: assert property (p_nar) else $error("narrow upper half set");
   property p_win; req[2].valid && ready[2] && req[2].addr < 32'h0000_00C0
      |-> win_req.valid && win_req.offset == req[2].addr[7:0]; endproperty
   a_win: assert property (p_win) else $error("window not used");
   property p_miss; req[4].valid && req[4].addr[31:16] != 16'h0000 |-> ready[4]; endproperty
   a_miss: assert property (p_miss) else $error("miss held");
   property p_dmiss; req[7].valid && req[7].addr[31:16] != 16'h0001 |-> ready[7]; endproperty
   a_dmiss: assert property (p_dmiss) else $error("dma miss held");
endmodule

// [sim/darb_win_model.sv]
// Register window behind the bank, answering in the same cycle.
// Assumes at most one window access per cycle from the bank.
`timescale 1ns/1ps
module darb_win_model (
   input  wire logic                clk,
   input  wire darb_pkg::darb_win_t win_req,
   output      logic [15:0]         win_rdata
);
   logic [15:0] regs [128] = '{default: 16'h0000};
   // Idle gives the inverse, so a stale sample cannot pass
   assign win_rdata = win_req.valid ? regs[win_req.offset[7:1]]
                                    : ~regs[win_req.offset[7:1]];
   always @(posedge clk) begin
      if (win_req.valid && win_req.we) regs[win_req.offset[7:1]] <= win_req.wdata;
   end
endmodule

// [sim/tb_top.sv]
// Self-checking bench for the dual-access RAM bank.
// Assumes the package, window model and checker compile first.
`timescale 1ns/1ps
`include "darb_regs.svh"
module tb_top;
   logic                clk = 1'b0;
   logic                sys_rst = 1'b1;
   darb_pkg::darb_req_t req [`DARB_NREQ];
   logic                ready [`DARB_NREQ];
   darb_pkg::darb_rsp_t rsp [`DARB_NREQ];
   darb_pkg::darb_win_t win_req;
   logic [15:0]         win_rdata;
   logic [15:0]         mem [int];
   logic [31:0]         expq [$];
   logic [31:0]         pool [8];
   int                  n_fail = 0, n_tests = 0, cycles = 0;
   int                  seed = 42;
   always #10 clk = ~clk;
   darb_bank darb_bank_i (.clk(clk), .sys_rst(sys_rst), .req(req), .ready(ready),
      .rsp(rsp), .win_req(win_req), .win_rdata(win_rdata));
   darb_win_model darb_win_model_i (.clk(clk), .win_req(win_req), .win_rdata(win_rdata));
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task print_verdict;
      if (n_fail == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task put(input int i, input logic we, input logic [31:0] a);
      req[i] <= '{1'b1, we, i < 2 || i > 5, a, 32'($random(seed))};
   endtask
   task automatic model(input int i);
      int k = req[i].addr[15:1];
      if (req[i].addr[31:16] != 16'(i > 5)) begin
         if (!req[i].we) expq.push_back(32'h0);
      end else if (!req[i].we)
         expq.push_back(req[i].wide ? {mem[k | 1], mem[k & ~1]} : {16'h0, mem[k]});
      else begin
         mem[req[i].wide ? k & ~1 : k] = req[i].wdata[15:0];
         if (req[i].wide) mem[k | 1] = req[i].wdata[31:16];
      end
   endtask
   // Reads first: a read beside a write to its word sees the old value
   task automatic run;
      bit busy = 1'b1;
      for (int c = 0; c < 60 && busy; c++) begin
         @(posedge clk);
         busy = 1'b0;
         for (int p = 0; p < 2; p++)
            for (int i = 0; i < `DARB_NREQ; i++)
               if (req[i].valid && req[i].we == p[0]) begin
                  if (ready[i]) begin
                     model(i);
                     req[i].valid <= 1'b0;
                  end else busy = 1'b1;
               end
      end
      if (busy) n_fail++;
   endtask
   always @(posedge clk) begin
      for (int i = 0; i < `DARB_NREQ; i++)
         if (rsp[i].rvalid === 1'b1)
            chk(rsp[i].rdata, expq.size() ? expq.pop_front() : 32'hDEAD_BEEF);
      cycles++;
      if (cycles > 3000) begin
         n_fail++;
         print_verdict;
      end
   end
   initial begin
      for (int i = 0; i < `DARB_NREQ; i++) req[i] = '0;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      // Wide DMA fill per block; CPU reads must find it below the offset
      for (int b = 0; b < 8; b++) begin
         pool[b] = {16'h0000, b[2:0], 13'h0100} | ($random(seed) & 32'h0000_1EFC);
         @(posedge clk);
         put(6, 1'b1, pool[b] + `DARB_DMA_OFFSET);
         run;
      end
      // Full load; first rounds pile every port onto block 3
      for (int n = 0; n < 40; n++) begin
         @(posedge clk);
         for (int i = 0; i < `DARB_NREQ; i++)
            put(i, i > 3 && (i < 6 || $random(seed) % 2 != 0), (i > 5 ? `DARB_DMA_OFFSET : 32'h0)
               + (pool[n < 4 ? 3 : $random(seed) & 7] | ($random(seed) & 2)));
         run;
      end
      @(posedge clk);
      put(2, 1'b1, 32'h10);
      put(5, 1'b1, 32'h22);
      put(4, 1'b1, 32'h2_0000);
      run;
      @(posedge clk);
      put(3, 1'b0, 32'h10);
      put(2, 1'b0, 32'h22);
      put(7, 1'b0, 32'h100);
      put(0, 1'b0, 32'h1_0000);
      run;
      repeat (3) @(posedge clk);
      chk(32'(expq.size()), 32'h0);
      print_verdict;
   end
endmodule
bind darb_bank darb_bank_properties darb_bank_properties_i (.clk(clk), .sys_rst(sys_rst),
   .req(req), .ready(ready), .rsp(rsp), .win_req(win_req), .win_rdata(win_rdata));
